//--- gpp_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH
`define GPP_OFS_DRIVE_ENABLE  8'h00
`define GPP_OFS_DE_SET        8'h01
`define GPP_OFS_DE_CLEAR      8'h02
`define GPP_OFS_DE_TOGGLE     8'h03
`define GPP_OFS_DRIVE_VALUE   8'h04
`define GPP_OFS_LEVEL_SET     8'h05
`define GPP_OFS_LEVEL_CLEAR   8'h06
`define GPP_OFS_LEVEL_TOGGLE  8'h07
`define GPP_OFS_INPUT_VALUE   8'h08
`define GPP_OFS_FLAGS         8'h09
`define GPP_OFS_PIN_CONTROL   8'h10
`define GPP_ALIAS_DRIVE_ENABLE 8'h00
`define GPP_ALIAS_DRIVE_VALUE  8'h01
`define GPP_ALIAS_INPUT_VALUE  8'h02
`define GPP_ALIAS_FLAGS        8'h03
`define GPP_BIT_INVERT_ENABLE 7
`define GPP_BIT_PULLUP_ENABLE 3
`define GPP_CTRL_RESET        8'h00
`define GPP_CTRL_MASK         8'h8F
`define GPP_DEAD_CYCLES       2'h3
`endif

//--- gpp_pkg.sv
// Types shared by the general purpose port.
package gpp_pkg;
  typedef enum logic [2:0] {
    GPP_SENSE_INTDISABLE = 3'h0,
    GPP_SENSE_BOTH_EDGES = 3'h1,
    GPP_SENSE_RISING     = 3'h2,
    GPP_SENSE_FALLING    = 3'h3,
    GPP_SENSE_INPUT_OFF  = 3'h4,
    GPP_SENSE_LEVEL_LOW  = 3'h5
  } gpp_sense_t;
endpackage

//--- gpp_port.sv
// General purpose I/O port: direction, level, input sync, sensing, events.
`timescale 1ns/1ps
`include "gpp_map.svh"
module gpp_port #(
  parameter int PINS = 8
) (
  input  wire logic            clock,
  input  wire logic            sys_rst,
  input  wire logic [7:0]      reg_addr,
  input  wire logic            reg_write,
  input  wire logic            reg_read,
  input  wire logic            alias_sel,
  input  wire logic [7:0]      reg_wdata,
  output logic      [7:0]      reg_rdata,
  input  wire logic [PINS-1:0] pin_in,
  output logic      [PINS-1:0] pin_out,
  output logic      [PINS-1:0] pin_oe,
  output logic      [PINS-1:0] pin_pullup,
  input  wire logic [PINS-1:0] periph_override,
  input  wire logic [PINS-1:0] periph_oe,
  input  wire logic [PINS-1:0] periph_out,
  input  wire logic [PINS-1:0] full_async,
  input  wire logic            clk_stopped,
  output logic      [PINS-1:0] pin_event,
  output logic                 port_irq,
  output logic                 wake_req
);
  import gpp_pkg::*;

  logic [PINS-1:0] drive_enable_q;
  logic [PINS-1:0] drive_value_q;
  logic [PINS-1:0] input_value_q;
  logic [PINS-1:0] flags_q;
  logic [7:0]      pin_control_q [PINS];
  logic [PINS-1:0] sync1_q;
  logic [PINS-1:0] sync2_q;
  logic [PINS-1:0] sync3_q;
  logic [PINS-1:0] prev_q;
  logic [PINS-1:0] async_hit_q;
  logic [1:0]      dead_q [PINS];
  logic [PINS-1:0] inv;
  logic [PINS-1:0] buf_on;
  logic [PINS-1:0] seen;
  logic [PINS-1:0] hit;
  logic [PINS-1:0] wake_pin;
  logic [PINS-1:0] wr_de_set;
  logic [PINS-1:0] wr_de_clr;
  logic [PINS-1:0] wr_de_tgl;
  logic [PINS-1:0] wr_de;
  logic [PINS-1:0] wr_dv;
  logic [PINS-1:0] wr_dv_set;
  logic [PINS-1:0] wr_dv_clr;
  logic [PINS-1:0] wr_dv_tgl;
  logic [PINS-1:0] wr_fl;
  logic            de_load;
  logic            dv_load;

  // Per-pin configuration decode.
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      inv[i]    = pin_control_q[i][`GPP_BIT_INVERT_ENABLE];
      buf_on[i] = gpp_sense_t'(pin_control_q[i][2:0]) != GPP_SENSE_INPUT_OFF;
    end
  end

  // Address decode; the alias window maps four registers onto the same
  // write strobes so both paths behave identically.
  always_comb begin
    wr_de_set = '0;
    wr_de_clr = '0;
    wr_de_tgl = '0;
    wr_dv_set = '0;
    wr_dv_clr = '0;
    wr_dv_tgl = '0;
    wr_fl     = '0;
    wr_de     = reg_wdata[PINS-1:0];
    wr_dv     = reg_wdata[PINS-1:0];
    de_load   = 1'b0;
    dv_load   = 1'b0;
    if (reg_write && alias_sel) begin
      if (reg_addr == `GPP_ALIAS_DRIVE_ENABLE) begin
        de_load = 1'b1;
      end else if (reg_addr == `GPP_ALIAS_DRIVE_VALUE) begin
        dv_load = 1'b1;
        wr_dv   = reg_wdata[PINS-1:0] ^ inv;
      end else if (reg_addr == `GPP_ALIAS_INPUT_VALUE) begin
        wr_dv_tgl = reg_wdata[PINS-1:0];
      end else if (reg_addr == `GPP_ALIAS_FLAGS) begin
        wr_fl = reg_wdata[PINS-1:0];
      end
    end else if (reg_write) begin
      if (reg_addr == `GPP_OFS_DRIVE_ENABLE) begin
        de_load = 1'b1;
      end else if (reg_addr == `GPP_OFS_DE_SET) begin
        wr_de_set = reg_wdata[PINS-1:0];
      end else if (reg_addr == `GPP_OFS_DE_CLEAR) begin
        wr_de_clr = reg_wdata[PINS-1:0];
      end else if (reg_addr == `GPP_OFS_DE_TOGGLE) begin
        wr_de_tgl = reg_wdata[PINS-1:0];
      end else if (reg_addr == `GPP_OFS_DRIVE_VALUE) begin
        dv_load = 1'b1;
        wr_dv   = reg_wdata[PINS-1:0] ^ inv;
      end else if (reg_addr == `GPP_OFS_LEVEL_SET) begin
        wr_dv_set = reg_wdata[PINS-1:0] & ~inv;
        wr_dv_clr = reg_wdata[PINS-1:0] & inv;
      end else if (reg_addr == `GPP_OFS_LEVEL_CLEAR) begin
        wr_dv_clr = reg_wdata[PINS-1:0];
      end else if (reg_addr == `GPP_OFS_LEVEL_TOGGLE) begin
        wr_dv_tgl = reg_wdata[PINS-1:0];
      end else if (reg_addr == `GPP_OFS_INPUT_VALUE) begin
        wr_dv_tgl = reg_wdata[PINS-1:0];
      end else if (reg_addr == `GPP_OFS_FLAGS) begin
        wr_fl = reg_wdata[PINS-1:0];
      end
    end
  end

  // Drive enable register; reset leaves every driver off.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      drive_enable_q <= '0;
    end else if (de_load) begin
      drive_enable_q <= wr_de;
    end else begin
      drive_enable_q <= ((drive_enable_q | wr_de_set) & ~wr_de_clr)
                        ^ wr_de_tgl;
    end
  end

  // Drive value register, stored as the true pin level.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      drive_value_q <= '0;
    end else if (dv_load) begin
      drive_value_q <= wr_dv;
    end else begin
      drive_value_q <= ((drive_value_q | wr_dv_set) & ~wr_dv_clr) ^ wr_dv_tgl;
    end
  end

  // Pin control registers at 0x10 plus pin index.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < PINS; i++) begin
        pin_control_q[i] <= `GPP_CTRL_RESET;
      end
    end else if (reg_write && !alias_sel &&
                 reg_addr >= `GPP_OFS_PIN_CONTROL &&
                 reg_addr < `GPP_OFS_PIN_CONTROL + 8'(PINS)) begin
      pin_control_q[3'(reg_addr - `GPP_OFS_PIN_CONTROL)] <=
        reg_wdata & `GPP_CTRL_MASK;
    end
  end

  // Three-stage synchronizer; a disabled buffer holds its stages, so the
  // input value freezes and a half-synchronized change may surface later
  // when the input is re-enabled.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (buf_on[i]) begin
          sync1_q[i] <= pin_in[i];
          sync2_q[i] <= sync1_q[i];
          sync3_q[i] <= sync2_q[i];
        end
      end
    end
  end

  // A change counts once the second and third stages agree.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      input_value_q <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (buf_on[i] && sync2_q[i] == sync3_q[i]) begin
          input_value_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // Internal view includes inversion, so toggling invert makes an edge.
  assign seen = input_value_q ^ inv;

  // Fully asynchronous pins register a hit while the second and third
  // synchronizer stages disagree; partial pins rely on the synchronized level.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q      <= '0;
      async_hit_q <= '0;
    end else begin
      prev_q      <= seen;
      async_hit_q <= full_async & (sync2_q ^ sync3_q) & buf_on;
    end
  end

  // Sense evaluation; the new sense applies at once, so a change during
  // synchronization may drop the pending event.
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      case (gpp_sense_t'(pin_control_q[i][2:0]))
        GPP_SENSE_BOTH_EDGES: hit[i] = seen[i] != prev_q[i];
        GPP_SENSE_RISING:     hit[i] = seen[i] && !prev_q[i];
        GPP_SENSE_FALLING:    hit[i] = !seen[i] && prev_q[i];
        GPP_SENSE_LEVEL_LOW:  hit[i] = !seen[i];
        default:              hit[i] = 1'b0;
      endcase
    end
  end

  // Flags: set wins over a software clear, with a three-cycle dead time.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= '0;
      for (int i = 0; i < PINS; i++) begin
        dead_q[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (hit[i] && dead_q[i] == 2'h0) begin
          flags_q[i] <= 1'b1;
          dead_q[i]  <= `GPP_DEAD_CYCLES;
        end else begin
          if (wr_fl[i]) begin
            flags_q[i] <= 1'b0;
          end
          if (dead_q[i] != 2'h0) begin
            dead_q[i] <= dead_q[i] - 2'h1;
          end
        end
      end
    end
  end

  // Wake on stopped clock: partial pins only for both-edges or level.
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      wake_pin[i] = buf_on[i] && (full_async[i] ||
        gpp_sense_t'(pin_control_q[i][2:0]) == GPP_SENSE_BOTH_EDGES ||
        gpp_sense_t'(pin_control_q[i][2:0]) == GPP_SENSE_LEVEL_LOW) &&
        gpp_sense_t'(pin_control_q[i][2:0]) != GPP_SENSE_INTDISABLE &&
        (seen[i] != prev_q[i] || async_hit_q[i] ||
         (!seen[i] && pin_control_q[i][2:0] == 3'h5));
    end
  end

  // Registered pin outputs; peripherals override only their pins.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out    <= '0;
      pin_oe     <= '0;
      pin_pullup <= '0;
      pin_event  <= '0;
      port_irq   <= 1'b0;
      wake_req   <= 1'b0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        pin_out[i] <= periph_override[i] ? periph_out[i] : drive_value_q[i];
        pin_oe[i]  <= periph_override[i] ? periph_oe[i]
                                          : drive_enable_q[i];
        pin_pullup[i] <= pin_control_q[i][`GPP_BIT_PULLUP_ENABLE] &&
                         !(periph_override[i] ? periph_oe[i]
                                              : drive_enable_q[i]);
        pin_event[i]  <= buf_on[i] & seen[i];
      end
      port_irq <= |flags_q;
      wake_req <= clk_stopped && |wake_pin;
    end
  end

  // Read data, registered; unmapped offsets read zero.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read && alias_sel) begin
      if (reg_addr == `GPP_ALIAS_DRIVE_ENABLE) begin
        reg_rdata <= 8'(drive_enable_q);
      end else if (reg_addr == `GPP_ALIAS_DRIVE_VALUE) begin
        reg_rdata <= 8'(drive_value_q ^ inv);
      end else if (reg_addr == `GPP_ALIAS_INPUT_VALUE) begin
        reg_rdata <= 8'(seen);
      end else if (reg_addr == `GPP_ALIAS_FLAGS) begin
        reg_rdata <= 8'(flags_q);
      end else begin
        reg_rdata <= 8'h00;
      end
    end else if (reg_read) begin
      if (reg_addr <= `GPP_OFS_DE_TOGGLE) begin
        reg_rdata <= 8'(drive_enable_q);
      end else if (reg_addr <= `GPP_OFS_LEVEL_TOGGLE) begin
        reg_rdata <= 8'(drive_value_q ^ inv);
      end else if (reg_addr == `GPP_OFS_INPUT_VALUE) begin
        reg_rdata <= 8'(seen);
      end else if (reg_addr == `GPP_OFS_FLAGS) begin
        reg_rdata <= 8'(flags_q);
      end else if (reg_addr >= `GPP_OFS_PIN_CONTROL &&
                   reg_addr < `GPP_OFS_PIN_CONTROL + 8'(PINS)) begin
        reg_rdata <= pin_control_q[3'(reg_addr - `GPP_OFS_PIN_CONTROL)];
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end
endmodule

//--- gpp_port_assertions.sv
// Checker for the bus and pin behaviour of the general purpose port.
`timescale 1ns/1ps
module gpp_port_chk #(
  parameter int PINS = 8
) (
  input wire logic            clock,
  input wire logic            sys_rst,
  input wire logic [7:0]      reg_addr,
  input wire logic            reg_write,
  input wire logic            reg_read,
  input wire logic            alias_sel,
  input wire logic [7:0]      reg_wdata,
  input wire logic [7:0]      reg_rdata,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic [PINS-1:0] pin_pullup,
  input wire logic [PINS-1:0] periph_override,
  input wire logic            port_irq
);
  logic [7:0] wd1_q;
  logic [7:0] wd2_q;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Write data two edges back, when a strobe reaches the drivers.
  always_ff @(posedge clock) begin
    wd1_q <= reg_wdata;
    wd2_q <= wd1_q;
  end
  // A main-map write while no peripheral holds any pin.
  sequence wr_at(logic [7:0] a);
    reg_write && !alias_sel && reg_addr == a && periph_override == '0;
  endsequence
  // A read with no write close enough to move drive enable.
  sequence quiet_de_read;
    reg_read && !reg_write && !$past(reg_write) && periph_override == '0
    && (alias_sel ? reg_addr == 8'h00 : reg_addr <= 8'h03);
  endsequence
  reset_oe_a: assert property ($fell(sys_rst) |-> pin_oe == '0)
    else $error("drivers enabled after reset");
  de_set_a: assert property (
    wr_at(8'h01) |-> ##2 (pin_oe & wd2_q) == wd2_q)
    else $error("set strobe missed a driver");
  de_clear_a: assert property (
    wr_at(8'h02) |-> ##2 (pin_oe & wd2_q) == 8'h00)
    else $error("clear strobe left a driver on");
  de_toggle_a: assert property (
    !$past(reg_write) ##0 wr_at(8'h03) ##1 !reg_write
    |=> pin_oe == ($past(pin_oe) ^ wd2_q))
    else $error("toggle strobe gave wrong drivers");
  pullup_off_a: assert property ((pin_pullup & pin_oe) == '0)
    else $error("pull-up on a driven pin");
  strobe_read_a: assert property (
    quiet_de_read |=> reg_rdata == pin_oe)
    else $error("drive enable read mismatch");
  unmapped_a: assert property (
    reg_read && !reg_write && (alias_sel ? reg_addr > 8'h03
    : (reg_addr > 8'h17 || reg_addr inside {[8'h0A:8'h0F]}))
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  irq_hold_a: assert property (
    port_irq && !reg_write && !$past(reg_write) |=> port_irq)
    else $error("request dropped without a clear");
endmodule
bind gpp_port gpp_port_chk #(.PINS(PINS)) u_chk (
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_read(reg_read), .alias_sel(alias_sel),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_oe(pin_oe),
  .pin_pullup(pin_pullup), .periph_override(periph_override),
  .port_irq(port_irq)
);

//--- gpp_pins_model.sv
// External pin world seen by the port: sources, pull-ups, floating pins.
`timescale 1ns/1ps
module gpp_pins_model (
  input  wire logic       clock,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_in
);
  logic [7:0] float_q = 8'h55;
  // A floating pin wanders so that a stale level never looks valid.
  always_ff @(posedge clock) begin
    float_q <= ~float_q;
  end
  // Port driver wins, then an outside source, then the pull-up.
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pin_pullup | float_q));
  end
endmodule

//--- gpp_port_pin_control_test.sv
// Self-checking bench for the general purpose port.
`timescale 1ns/1ps
module gpp_port_pin_control_test;
  logic       clock, sys_rst, reg_write, reg_read, alias_sel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_in, pin_out, pin_oe;
  logic [7:0] pin_pullup, periph_override, periph_oe, periph_out;
  logic [7:0] full_async, pin_event, ext_en, ext_val, de, tv, inv, d, r;
  logic       clk_stopped, port_irq, wake_req;
  int         errors, cmp_count, op;
  gpp_port DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .alias_sel(alias_sel),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .periph_override(periph_override), .periph_oe(periph_oe),
    .periph_out(periph_out), .full_async(full_async),
    .clk_stopped(clk_stopped), .pin_event(pin_event),
    .port_irq(port_irq), .wake_req(wake_req));
  gpp_pins_model u_pins (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));
  // Free-running clock, 50 ns period.
  always #25 clock = ~clock;
  // Compares one value; a mismatch is reported and counted.
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // One-cycle strobes launched at the falling edge, then a quiet edge.
  task automatic wr(logic [7:0] a, logic [7:0] v, logic al = 1'b0);
    @(negedge clock);
    {reg_addr, reg_wdata, alias_sel, reg_write} = {a, v, al, 1'b1};
    @(negedge clock);
    reg_write = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, string n,
                    logic al = 1'b0);
    @(negedge clock);
    {reg_addr, alias_sel, reg_read} = {a, al, 1'b1};
    @(negedge clock);
    reg_read = 1'b0;
    chk(n, reg_rdata, e);
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence; the model keeps drive enable, true level and invert.
  initial begin
    {clock, reg_write, reg_read, alias_sel, clk_stopped} = '0;
    {reg_addr, reg_wdata, periph_override, periph_oe, periph_out} = '0;
    {full_async, de, tv, inv} = '0;
    {sys_rst, ext_en, ext_val} = {1'b1, 8'hFF, 8'hA5};
    void'($urandom(32'hA219));
    cyc(6);
    sys_rst = 1'b0;
    cyc(8);
    chk("oe", pin_oe, 8'h00);
    chk("event", pin_event, ext_val);
    for (int a = 0; a < 32; a++) rd(a, a == 8 ? ext_val : 0, "rst");
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      op = $urandom_range(3);
      d = $urandom;
      wr(op, d, op == 0 && i[0]);
      case (op) 0: de = d; 1: de |= d; 2: de &= ~d; default: de ^= d; endcase
      rd(1 + i % 3, de, "de_strobe");
      rd(0, de, "de_alias", 1'b1);
      chk("pin_oe", pin_oe, de);
    end
    $display("drive enable test done");
    inv = $urandom;
    for (int n = 0; n < 8; n++) begin
      wr(8'h10 + n, {inv[n], 7'h0});
      rd(8'h10 + n, {inv[n], 7'h0}, "ctrl");
    end
    for (int i = 0; i < 12; i++) begin
      op = $urandom_range(8, 4);
      d = $urandom;
      r = tv ^ inv;
      wr(op, d);
      // Clear acts on the true level; value write, set and toggle act on the inverted view.
      case (op)
        4: r = d;
        5: r |= d;
        6: r = (tv & ~d) ^ inv;
        default: r ^= d;
      endcase
      tv = r ^ inv;
      rd(4, r, "level");
      rd(1, r, "level_alias", 1'b1);
      chk("pin_out", pin_out & de, tv & de);
      cyc(8);
      rd(8, ((de & tv) | (~de & ext_val)) ^ inv, "input");
    end
    $display("level test done");
    {de, inv} = '0;
    wr(0, 8'h00);
    cyc(8);
    for (int n = 0; n < 8; n++) wr(8'h10 + n, n < 4 ? 8'h0C : 8'h08);
    {ext_en, ext_val} = {8'h0F, 8'h0A};
    cyc(8);
    chk("pullup", pin_pullup, 8'hFF);
    chk("event_off", pin_event, 8'hF0);
    rd(8, 8'hF5, "frozen");
    wr(1, 8'h30);
    de = 8'h30;
    cyc(8);
    chk("pullup_drv", pin_pullup, 8'hCF);
    rd(8, {2'b11, tv[5:4], 4'h5}, "mixed");
    $display("pull-up test done");
    for (int c = 0; c < 6; c++) begin
      ext_val[0] = 1'b1;
      wr(8'h10, c);
      cyc(8);
      wr(9, 8'hFF);
      cyc(4);
      rd(9, 0, "idle");
      ext_val[0] = 1'b0;
      cyc(8);
      rd(9, c inside {1, 3, 5}, "fall");
      wr(9, 8'hFE);
      rd(9, c inside {1, 3, 5}, "keep");
      wr(9, 8'hFF);
      cyc(4);
      rd(9, c == 5, "low");
      ext_val[0] = 1'b1;
      cyc(8);
      chk("irq", port_irq, c inside {1, 2, 5});
    end
    // Invert changes alone, never with the sense field.
    wr(8'h10, 8'h02);
    wr(8'h10, 8'h82);
    cyc(8);
    wr(9, 8'hFF);
    cyc(4);
    wr(8'h10, 8'h02);
    cyc(8);
    rd(9, 8'h01, "inv_edge");
    $display("sense test done");
    {periph_override, periph_oe, periph_out} = {8'hFF, 16'($urandom)};
    cyc(4);
    chk("ovr_oe", pin_oe, periph_oe);
    chk("ovr_out", pin_out & periph_oe, periph_out & periph_oe);
    periph_override = 8'h0F;
    cyc(4);
    chk("ovr_part", pin_oe, {de[7:4], periph_oe[3:0]});
    periph_override = 8'h00;
    $display("override test done");
    // Clock marked stopped: a partial pin wakes on both-edges sensing, not on rising.
    clk_stopped = 1'b1;
    for (int c = 0; c < 3; c++) begin
      full_async[0] = c == 2;
      wr(8'h10, c == 0 ? 8'h01 : 8'h02);
      ext_val[0] = 1'b0;
      cyc(8);
      ext_val[0] = 1'b1;
      op = 0;
      repeat (12) begin
        @(negedge clock);
        op |= wake_req;
      end
      chk("wake", op, c != 1);
    end
    clk_stopped = 1'b0;
    $display("wake test done");
    wrap_up();
  end
endmodule
